// [logic/charger_power_up_sequencer.sv]
// charger_power_up_sequencer: power-up and power-path sequencing logic
// assumes comparator levels arrive asynchronously; host bits arrive on this clock
// Function
// - supply release resets the host control bits, not shipping mode
// - battery only: switch on, bias off
// - overload trips switch until input returns
// - disable bit forces switch off, no path
// - adapter connection turns switch back on
// - bias on after conditions and delay
// - failed condition: high impedance, battery feeds
// - voltage check first, then current limit
// - start buck only if source qualifies
// - boost current follows select bit
// - blocking switch trip follows select bit
// - good source: status, pin low, interrupt
// - poor source retried every two seconds
module charger_power_up_sequencer
   import power_seq_pkg::*;
#(
   parameter int unsigned QUAL_CYCLES  = QUAL_DELAY_CYCLES,
   parameter int unsigned RETRY_CYCLES = RETRY_PERIOD_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clk_en,
   input  wire logic       input_above_release,    // input supply above release level
   input  wire logic       battery_above_release,  // battery above release level
   input  wire logic       battery_above_depletion,
   input  wire logic       input_above_sleep_exit, // input above battery plus offset
   input  wire logic       battery_overload,       // overload through battery switch
   input  wire logic       source_good,            // current capability check passed
   input  wire logic       source_check_done,      // current capability check finished
   input  wire logic       ilim_done,              // input current limit detection done
   input  wire logic       boost_request_pin,
   input  wire logic       reg_write,              // host register write strobe
   input  wire logic       wr_battery_switch_disable_bit,
   input  wire logic [1:0] wr_watchdog_period_field,
   input  wire logic       wr_boost_current_select,
   output logic            interface_ready,
   output logic            battery_switch_on,
   output logic            bias_regulator_en,
   output logic            high_impedance_state,
   output logic            source_check_start,
   output logic            ilim_detect_start,
   output logic            buck_enable,
   output logic            boost_current_high,     // 1.3 A capability when set
   output logic            reverse_block_trip_high,// 1.8 A trip level when set
   output logic            power_good_status,
   output logic            power_good_pin_n,
   output logic            host_interrupt,
   output logic            battery_switch_disable_bit,
   output logic [1:0]      watchdog_period_field,
   output logic            boost_current_select,
   output logic            shipping_mode
);
   logic [6:0]  sync_w;           // synchronised comparator levels
   logic        vin_ok;           // input above release
   logic        vbat_ok;          // battery above release
   logic        dep_ok;           // battery above depletion
   logic        sleep_ok;         // input above battery plus offset
   logic        ovl;              // switch overload
   logic        boost_mode;       // boost request from pin
   logic        good;             // qualification result
   logic        por_ok;           // either supply released
   logic        por_d_r;          // last cycle release state
   logic        cond_ok;          // all bias enable conditions
   logic        overload_trip_r;  // sticky overload latch
   logic        vin_d_r;          // last cycle input state
   logic        plug_in;          // input rising edge
   logic [31:0] cnt_r;            // delay and retry counter
   logic        ilim_sent_r;      // current limit detection issued
   seq_state_t  state_r;
   seq_state_t  state_nxt;

   // comparator outputs cross into the clock domain here
   pin_sync #(.WIDTH(7)) u_sync (
      .clock    (clock),
      .rst      (rst),
      .clk_en   (clk_en),
      .async_in ({input_above_release, battery_above_release, battery_above_depletion,
                  input_above_sleep_exit, battery_overload, boost_request_pin, source_good}),
      .sync_out (sync_w)
   );
   assign {vin_ok, vbat_ok, dep_ok, sleep_ok, ovl, boost_mode, good} = sync_w;

   assign por_ok  = vin_ok | vbat_ok;
   assign plug_in = vin_ok & ~vin_d_r;
   // buck needs input above offset, boost needs it below
   assign cond_ok = vin_ok & (boost_mode ? ~sleep_ok : sleep_ok);

   // edge history for release and plug-in
   always_ff @(posedge clock) begin
      if (rst) begin
         por_d_r <= 1'b0;
         vin_d_r <= 1'b0;
      end else if (clk_en) begin
         por_d_r <= por_ok;
         vin_d_r <= vin_ok;
      end
   end

   // host control bits; reset again when a supply comes up
   always_ff @(posedge clock) begin
      if (rst || (clk_en && por_ok && !por_d_r)) begin
         battery_switch_disable_bit <= SW_DISABLE_RESET;
         watchdog_period_field      <= WDOG_RESET;
         boost_current_select       <= BOOST_SEL_RESET;
      end else if (clk_en) begin
         if (reg_write) begin
            battery_switch_disable_bit <= wr_battery_switch_disable_bit;
            watchdog_period_field      <= wr_watchdog_period_field;
            boost_current_select       <= wr_boost_current_select;
         end else if (plug_in) begin
            battery_switch_disable_bit <= 1'b0; // adapter re-enables switch
         end
      end
   end

   // interface comes up once any supply is released
   always_ff @(posedge clock) begin
      if (rst) begin
         interface_ready <= 1'b0;
      end else if (clk_en) begin
         interface_ready <= por_ok;
      end
   end

   // shipping mode needs both fields written in one access
   always_ff @(posedge clock) begin
      if (rst) begin
         shipping_mode <= 1'b0;
      end else if (clk_en) begin
         if (reg_write) begin
            shipping_mode <= wr_battery_switch_disable_bit
                             && (wr_watchdog_period_field == WDOG_DISABLED);
         end else if (plug_in) begin
            shipping_mode <= 1'b0;
         end
      end
   end

   // overload latch; overload wins over a same-cycle plug-in
   always_ff @(posedge clock) begin
      if (rst) begin
         overload_trip_r <= 1'b0;
      end else if (clk_en) begin
         // the switch drive already drops on ovl, so gating on it would never latch
         if (ovl) begin
            overload_trip_r <= 1'b1;
         end else if (plug_in) begin
            overload_trip_r <= 1'b0;
         end
      end
   end

   // switch drive: combinational so an overload cuts it at once
   always_comb begin
      battery_switch_on = dep_ok & ~overload_trip_r & ~ovl
                          & ~battery_switch_disable_bit;
   end

   // next state of the sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF, ST_BATTERY: begin
            if (cond_ok) begin
               state_nxt = ST_WAIT;
            end else if (dep_ok) begin
               state_nxt = ST_BATTERY;
            end else begin
               state_nxt = ST_OFF;
            end
         end
         ST_WAIT: begin
            if (!cond_ok) begin
               state_nxt = ST_BATTERY; // drop restarts the delay
            end else if (cnt_r >= QUAL_CYCLES - 1) begin
               state_nxt = ST_QUALIFY;
            end
         end
         ST_QUALIFY: begin
            if (!cond_ok) begin
               state_nxt = ST_BATTERY;
            end else if (source_check_done) begin
               state_nxt = good ? ST_RUN : ST_RETRY;
            end
         end
         ST_RETRY: begin
            if (!cond_ok) begin
               state_nxt = ST_BATTERY;
            end else if (cnt_r >= RETRY_CYCLES - 1) begin
               state_nxt = ST_QUALIFY;
            end
         end
         ST_RUN: begin
            if (!cond_ok) begin
               state_nxt = ST_BATTERY;
            end
         end
         default: state_nxt = ST_OFF;
      endcase
   end

   // state register
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= ST_OFF;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   // one counter serves the delay and the retry wait
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (clk_en) begin
         if (state_nxt != state_r) begin
            cnt_r <= '0;
         end else if (state_r == ST_WAIT || state_r == ST_RETRY) begin
            cnt_r <= cnt_r + 32'h1;
         end
      end
   end

   // current limit detection requested once per run entry
   always_ff @(posedge clock) begin
      if (rst) begin
         ilim_sent_r <= 1'b0;
      end else if (clk_en) begin
         ilim_sent_r <= (state_r == ST_RUN);
      end
   end

   // registered outputs tracking the state and the boost select bit
   always_ff @(posedge clock) begin
      if (rst) begin
         bias_regulator_en       <= 1'b0;
         high_impedance_state    <= 1'b1;
         source_check_start      <= 1'b0;
         ilim_detect_start       <= 1'b0;
         buck_enable             <= 1'b0;
         power_good_status       <= 1'b0;
         power_good_pin_n        <= 1'b1;
         host_interrupt          <= 1'b0;
         boost_current_high      <= 1'b0;
         reverse_block_trip_high <= 1'b0;
      end else if (clk_en) begin
         bias_regulator_en    <= (state_nxt == ST_QUALIFY) || (state_nxt == ST_RETRY)
                                 || (state_nxt == ST_RUN);
         high_impedance_state <= !((state_nxt == ST_QUALIFY) || (state_nxt == ST_RETRY)
                                 || (state_nxt == ST_RUN));
         source_check_start   <= (state_nxt == ST_QUALIFY) && (state_r != ST_QUALIFY);
         ilim_detect_start    <= (state_r == ST_RUN) && !ilim_sent_r;
         // leaving run drops the buck in the same cycle as power good
         buck_enable          <= (state_nxt == ST_RUN) && (state_r == ST_RUN)
                                 && ilim_done;
         power_good_status    <= (state_nxt == ST_RUN);
         power_good_pin_n     <= !(state_nxt == ST_RUN);
         host_interrupt       <= (state_nxt == ST_RUN) && (state_r != ST_RUN);
         boost_current_high      <= boost_current_select;
         reverse_block_trip_high <= boost_current_select;
      end
   end
endmodule

// [logic/power_seq_pkg.sv]
// power_seq_pkg: constants and types shared by the power-up sequencer
// assumes a single 100 MHz clock domain
package power_seq_pkg;
   localparam int unsigned CLOCK_HZ            = 100_000_000; // system clock rate
   localparam int unsigned QUAL_DELAY_MS       = 220;         // typical bias enable delay
   localparam int unsigned QUAL_DELAY_CYCLES   = QUAL_DELAY_MS * (CLOCK_HZ / 1000);
   localparam int unsigned RETRY_PERIOD_S      = 2;           // poor source retry period
   localparam int unsigned RETRY_PERIOD_CYCLES = RETRY_PERIOD_S * CLOCK_HZ;
   localparam int unsigned SYNC_STAGES         = 2;           // pin synchroniser depth
   localparam logic [1:0]  WDOG_DISABLED       = 2'h0;        // watchdog field value for off
   localparam logic        BOOST_SEL_RESET     = 1'h0;        // boost select after reset
   localparam logic        SW_DISABLE_RESET    = 1'h0;        // switch disable after reset
   localparam logic [1:0]  WDOG_RESET          = 2'h1;        // watchdog field after reset
   // sequencer states
   typedef enum logic [2:0] {
      ST_OFF,        // no usable supply, bias off
      ST_BATTERY,    // battery only, switch feeding system
      ST_WAIT,       // enable conditions held, counting delay
      ST_QUALIFY,    // bias up, source qualification running
      ST_RETRY,      // poor source, waiting before retry
      ST_RUN         // source good, buck converter running
   } seq_state_t;
endpackage

// [logic/pin_sync.sv]
// pin_sync: two-flop synchroniser bank for asynchronous inputs
// assumes clock enable freezes the stages with the rest of the block
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_r; // first stage, read only by second

   // two stages; metastability settles in the first
   always_ff @(posedge clock) begin
      if (rst) begin
         stage1_r <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         stage1_r <= async_in;
         sync_out <= stage1_r;
      end
   end
endmodule

// [dv/seq_chk.sv]
// checker on the power-up sequencer ports, attached by bind
// assumes one clock domain and the synchronous active-high reset of the design
module seq_chk #(
   parameter int unsigned QUAL_CYCLES = 20
) (
   input wire logic clock, rst, input_above_release, battery_overload,
   input wire logic battery_switch_on, battery_switch_disable_bit, boost_current_select,
   input wire logic bias_regulator_en, high_impedance_state, buck_enable,
   input wire logic boost_current_high, reverse_block_trip_high, shipping_mode,
   input wire logic power_good_status, power_good_pin_n, host_interrupt, ilim_detect_start
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   int unsigned run_r; // cycles the input has stayed released
   // counter lets the long qualifying delay be checked without a huge repetition
   always_ff @(posedge clock) run_r <= input_above_release ? run_r + 1 : 0;
   a_pin_follows:
   assert property (power_good_pin_n == !power_good_status) else $error("pin not inverse");
   a_boost_cap:
   assert property (boost_current_high == $past(boost_current_select))
      else $error("boost cap");
   a_trip_level:
   assert property (reverse_block_trip_high == $past(boost_current_select))
      else $error("trip level");
   a_switch_forced:
   assert property (battery_switch_disable_bit |-> !battery_switch_on) else $error("switch on");
   a_hiz_bias:
   assert property (bias_regulator_en != high_impedance_state) else $error("hiz and bias");
   a_bias_delay:
   assert property ($rose(bias_regulator_en) |-> run_r >= QUAL_CYCLES) else $error("bias early");
   a_good_irq:
   assert property ($rose(power_good_status) |-> host_interrupt ##1 ilim_detect_start)
      else $error("good source without interrupt");
   a_buck_order:
   assert property (buck_enable |-> power_good_status && bias_regulator_en) else $error("buck");
   a_overload_off:
   assert property (battery_overload [*3] |=> !battery_switch_on) else $error("overload");
   c_good: cover property ($rose(power_good_status));
   c_trip: cover property ($fell(battery_switch_on));
   c_ship: cover property ($rose(shipping_mode));
endmodule
bind charger_power_up_sequencer seq_chk #(.QUAL_CYCLES(QUAL_CYCLES)) u_chk (.*);

// [dv/src_model.sv]
// input source model: supply levels and capability answers
// assumes start pulses from the sequencer on the same clock
module src_model (
   input  wire logic       clock,
   input  wire logic       plug, poor, source_check_start, ilim_detect_start,
   input  wire logic [3:0] lat,            // answer delay, small or slow
   output logic            input_above_release, input_above_sleep_exit,
   output logic            source_good = 1'b0,
   output logic            source_check_done = 1'b0,
   output logic            ilim_done = 1'b0
);
   logic [3:0] cnt_r;                      // cycles left before answer
   logic       busy_r = 1'b0;              // check in progress
   assign input_above_release = plug;      // levels follow the plug
   assign input_above_sleep_exit = plug;
   // capability check; unplugged source leaves a toggling level, never a stale one
   always_ff @(posedge clock) begin
      source_check_done <= 1'b0;
      if (!plug) begin
         busy_r <= 1'b0;
         source_good <= ~source_good;
      end else if (source_check_start) begin
         busy_r <= 1'b1;
         cnt_r <= lat;
         source_good <= !poor;
      end else if (busy_r && cnt_r == 4'h0) begin
         busy_r <= 1'b0;
         source_check_done <= 1'b1;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
   // current limit detection finishes the cycle after its start
   always_ff @(posedge clock) ilim_done <= plug && (ilim_done || ilim_detect_start);
endmodule

// [dv/charger_power_up_sequencer_tb_top.sv]
// self-checking bench for the power-up sequencer
// assumes short delay parameters so the run stays brief
module charger_power_up_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import power_seq_pkg::*;
   localparam int QC = 20, RC = 30;
   typedef struct packed {logic dep, dis, sel, on;} row_t;
   row_t rows [4] = '{4'h9, 4'hE, 4'h6, 4'hB}; // third row: no battery, host disables
   logic clock = 0, rst = 1, clk_en = 1, battery_above_release = 1, boost_request_pin = 0;
   logic battery_above_depletion = 1, battery_overload = 0, reg_write = 0, plug = 0, poor = 0;
   logic wr_battery_switch_disable_bit = 0, wr_boost_current_select = 0;
   logic [1:0] wr_watchdog_period_field = 2'h1;
   logic [3:0] lat = 4'h3;
   logic input_above_release, input_above_sleep_exit, source_good, source_check_done;
   logic ilim_done, interface_ready, battery_switch_on, bias_regulator_en, buck_enable;
   logic high_impedance_state, source_check_start, ilim_detect_start, boost_current_high;
   logic reverse_block_trip_high, power_good_status, power_good_pin_n, host_interrupt;
   logic battery_switch_disable_bit, boost_current_select, shipping_mode;
   logic [1:0] watchdog_period_field;
   int errors = 0, n_compared = 0, cyc = 0;
   charger_power_up_sequencer #(.QUAL_CYCLES(QC), .RETRY_CYCLES(RC)) dut (.*);
   src_model src (.*);
   always #5 clock = ~clock;
   // hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic hw(input logic d, input logic [1:0] w, input logic s);
      reg_write = 1;
      wr_battery_switch_disable_bit = d;
      wr_watchdog_period_field = w;
      wr_boost_current_select = s;
      step(1);
      reg_write = 0;
      step(1);
   endtask
   task automatic wait_pg(input int n);
      repeat (n) if (power_good_status !== 1'b1) step(1);
   endtask
   task automatic end_sim();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      step(3);
      chk("hiz", high_impedance_state, 1);
      chk("pin", power_good_pin_n, 1);
      chk("wdog", watchdog_period_field, WDOG_RESET);
      rst = 0;
      step(4);
      chk("ready", interface_ready, 1);
      foreach (rows[i]) begin
         battery_above_depletion = rows[i].dep;
         hw(rows[i].dis, 2'h1, rows[i].sel);
         step(2);
         chk("switch", battery_switch_on, rows[i].on);
         chk("boost", boost_current_high, rows[i].sel);
         chk("trip", reverse_block_trip_high, rows[i].sel);
         chk("bias", bias_regulator_en, 0);
      end
      hw(1, WDOG_DISABLED, 0); // both fields in one write
      chk("ship", shipping_mode, 1);
      chk("switch", battery_switch_on, 0);
      plug = 1;
      step(4);
      chk("dis", battery_switch_disable_bit, 0);
      chk("switch", battery_switch_on, 1);
      step(QC - 4);
      chk("bias", bias_regulator_en, 0);
      wait_pg(40);
      chk("good", power_good_status, 1);
      chk("bias", bias_regulator_en, 1);
      step(6);
      chk("buck", buck_enable, 1);
      plug = 0;
      step(5);
      chk("hiz", high_impedance_state, 1);
      plug = 1;
      step(10);
      plug = 0;
      step(3);
      plug = 1;
      step(QC - 2);
      chk("bias", bias_regulator_en, 0);
      plug = 0;
      step(5);
      poor = 1;
      lat = 4'h9;
      plug = 1;
      step(QC + 20);
      chk("good", power_good_status, 0);
      poor = 0;
      wait_pg(RC + 30);
      chk("good", power_good_status, 1);
      plug = 0;
      step(5);
      battery_overload = 1;
      step(4);
      battery_overload = 0;
      step(4);
      chk("switch", battery_switch_on, 0);
      plug = 1;
      step(4);
      chk("switch", battery_switch_on, 1);
      // boost mode wants the input below the offset, which this source never gives
      boost_request_pin = 1;
      step(QC + 10);
      chk("bias", bias_regulator_en, 0);
      chk("hiz", high_impedance_state, 1);
      end_sim();
   end
endmodule
